// >>> rtl/hum_host_end.sv
// master end: launches a humidity conversion, polls ready, reads the result
// assumes the sensor end never stretches the clock
module hum_host_end
    import hum_pkg::*;
#(
    parameter int unsigned QUARTER_CYC = I2C_QUARTER_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // two-wire link
    hum_i2c_if.host bus,
    // measurement request and result
    input wire logic meas_start_i,
    input wire logic fast_i,
    output logic busy_o,
    output logic done_o,
    output logic nack_o,
    output logic [CODE_W-1:0] humidity_code_o,
    output logic [7:0] rh_percent_o
);
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SCOND = 4'b0010,
        HS_BYTE = 4'b0100,
        HS_PCOND = 4'b1000
    } hum_host_state_e;

    localparam logic [1:0] OP_S = 2'h0;
    localparam logic [1:0] OP_W = 2'h1;
    localparam logic [1:0] OP_R = 2'h2;
    localparam logic [1:0] OP_P = 2'h3;
    localparam logic [4:0] STEP_STATUS = 5'd11;
    localparam logic [4:0] STEP_POLL_END = 5'd12;
    localparam logic [4:0] STEP_POLL = 5'd5;
    localparam logic [4:0] STEP_HI = 5'd19;
    localparam logic [4:0] STEP_LO = 5'd20;
    localparam logic [4:0] STEP_LAST = 5'd21;
    localparam logic [7:0] ADDR_WR = {DEV_ADDR, 1'b0};
    localparam logic [7:0] ADDR_RD = {DEV_ADDR, 1'b1};

    hum_host_state_e state, next_state;
    logic [2:0] sda_sync, next_sda_sync;
    logic sda_f, next_sda_f, scl_oe, next_scl_oe, sda_oe, next_sda_oe;
    logic [15:0] qdiv, next_qdiv;
    logic [1:0] q, next_q;
    logic [3:0] bitn, next_bitn;
    logic [4:0] seq, next_seq;
    logic [9:0] op, next_op;
    logic [7:0] shreg, next_shreg, hi, next_hi;
    logic fast_r, next_fast_r, busy, next_busy, done, next_done, nack, next_nack;
    logic [CODE_W-1:0] code, next_code;
    logic [7:0] pct, next_pct, rh_raw;
    logic tick, advance;

    // program: launch, poll status until ready low, then high byte then low byte
    function automatic logic [9:0] op_at(input logic [4:0] s, input logic fst);
        logic [9:0] o;
        o = {OP_P, 8'h00};
        case (s)
            5'd0, 5'd5, 5'd9, 5'd13, 5'd17: o = {OP_S, 8'h00};
            5'd1, 5'd6, 5'd14: o = {OP_W, ADDR_WR};
            5'd2: o = {OP_W, REG_CTRL};
            5'd3: o = {OP_W, 2'b00, fst, 4'h0, 1'b1};
            5'd7: o = {OP_W, REG_STATUS};
            5'd10, 5'd18: o = {OP_W, ADDR_RD};
            5'd11, 5'd20: o = {OP_R, 8'h00};
            5'd15: o = {OP_W, REG_RES_HI};
            5'd19: o = {OP_R, 8'h01};
            default: o = {OP_P, 8'h00};
        endcase
        return o;
    endfunction : op_at

    function automatic hum_host_state_e state_of(input logic [1:0] kind);
        hum_host_state_e st;
        st = HS_PCOND;
        if (kind == OP_S) begin
            st = HS_SCOND;
        end else if (kind == OP_W || kind == OP_R) begin
            st = HS_BYTE;
        end
        return st;
    endfunction : state_of

    always_comb begin
        next_sda_sync = {sda_sync[1:0], bus.sda};
        next_sda_f = sda_f;
        if (sda_sync[1] == sda_sync[2]) begin
            next_sda_f = sda_sync[2];
        end
        next_state = state;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_qdiv = qdiv;
        next_q = q;
        next_bitn = bitn;
        next_seq = seq;
        next_op = op;
        next_shreg = shreg;
        next_hi = hi;
        next_fast_r = fast_r;
        next_busy = busy;
        next_done = 1'b0;
        next_nack = nack;
        next_code = code;
        next_pct = pct;
        tick = 1'b0;
        advance = 1'b0;
        // quarter-bit enable; the default QUARTER_CYC keeps the bus at or below 400 kHz
        if (state != HS_IDLE) begin
            if (qdiv == 16'(QUARTER_CYC - 1)) begin
                next_qdiv = 16'h0000;
                tick = 1'b1;
                next_q = q + 2'h1;
            end else begin
                next_qdiv = qdiv + 16'h0001;
            end
        end
        case (state)
            HS_IDLE: begin
                if (meas_start_i) begin
                    next_fast_r = fast_i;
                    next_busy = 1'b1;
                    next_nack = 1'b0;
                    next_seq = 5'd0;
                    next_op = op_at(5'd0, fast_i);
                    next_state = HS_SCOND;
                    next_qdiv = 16'h0000;
                    next_q = 2'h0;
                end
            end
            HS_SCOND: begin
                if (tick) begin
                    if (q == 2'h0) begin
                        next_scl_oe = 1'b0;
                        next_sda_oe = 1'b0;
                    end else if (q == 2'h1) begin
                        next_sda_oe = 1'b1;
                    end else if (q == 2'h2) begin
                        next_scl_oe = 1'b1;
                    end else begin
                        advance = 1'b1;
                    end
                end
            end
            HS_PCOND: begin
                if (tick) begin
                    if (q == 2'h0) begin
                        next_sda_oe = 1'b1;
                    end else if (q == 2'h1) begin
                        next_scl_oe = 1'b0;
                    end else if (q == 2'h2) begin
                        next_sda_oe = 1'b0;
                    end else begin
                        advance = 1'b1;
                    end
                end
            end
            HS_BYTE: begin
                if (tick) begin
                    if (q == 2'h0) begin
                        if (bitn == 4'h8) begin
                            next_sda_oe = (op[9:8] == OP_R) && op[0];
                        end else begin
                            next_sda_oe = (op[9:8] == OP_W) && !shreg[7];
                        end
                    end else if (q == 2'h1) begin
                        next_scl_oe = 1'b0;
                    end else if (q == 2'h2) begin
                        if (bitn == 4'h8) begin
                            next_nack = nack || ((op[9:8] == OP_W) && sda_f);
                        end else begin
                            next_shreg = {shreg[6:0], sda_f};
                        end
                    end else begin
                        next_scl_oe = 1'b1;
                        next_bitn = bitn + 4'h1;
                        advance = (bitn == 4'h8);
                    end
                end
            end
            default: begin
                next_state = HS_IDLE;
            end
        endcase
        if (advance) begin
            next_seq = seq + 5'd1;
            if (seq == STEP_HI) begin
                next_hi = shreg;
            end
            if (seq == STEP_LO) begin
                next_code = {hi, shreg[7:4]};
            end
            if (seq == STEP_POLL_END && hi[STATUS_RDY_N_BIT]) begin
                next_seq = STEP_POLL;
            end
            if (seq == STEP_STATUS) begin
                next_hi = shreg;
            end
            if (seq == STEP_LAST) begin
                next_state = HS_IDLE;
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_op = op_at(next_seq, fast_r);
                next_state = state_of(next_op[9:8]);
                next_shreg = next_op[7:0];
                next_bitn = 4'h0;
            end
        end
        // percent = code/16 - 24, clamped to 0..100
        rh_raw = code[CODE_W-1:4];
        if (rh_raw < RH_OFFSET) begin
            next_pct = 8'h00;
        end else if (rh_raw - RH_OFFSET > RH_MAX) begin
            next_pct = RH_MAX;
        end else begin
            next_pct = rh_raw - RH_OFFSET;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= HS_IDLE;
            sda_sync <= 3'h7;
            sda_f <= 1'b1;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            qdiv <= 16'h0000;
            q <= 2'h0;
            bitn <= 4'h0;
            seq <= 5'd0;
            op <= 10'h000;
            shreg <= 8'h00;
            hi <= 8'h00;
            fast_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            code <= '0;
            pct <= 8'h00;
        end else begin
            state <= next_state;
            sda_sync <= next_sda_sync;
            sda_f <= next_sda_f;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            qdiv <= next_qdiv;
            q <= next_q;
            bitn <= next_bitn;
            seq <= next_seq;
            op <= next_op;
            shreg <= next_shreg;
            hi <= next_hi;
            fast_r <= next_fast_r;
            busy <= next_busy;
            done <= next_done;
            nack <= next_nack;
            code <= next_code;
            pct <= next_pct;
        end
    end

    assign bus.host_scl_oe = scl_oe;
    assign bus.host_sda_oe = sda_oe;
    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign busy_o = busy;
    assign done_o = done;
    assign nack_o = nack;
    assign humidity_code_o = code;
    assign rh_percent_o = pct;
endmodule : hum_host_end

// >>> rtl/hum_pkg.sv
// shared constants for the humidity readout link: register map, fields, timing
// assumes a single 100 MHz system clock on both ends
package hum_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam int CLK_PERIOD_NS = 10;
    localparam int I2C_MAX_KHZ = 400;
    localparam int I2C_PERIOD_NS = 1000000 / I2C_MAX_KHZ;
    // a least time, so the quarter bit rounds up
    localparam int I2C_QUARTER_CYC = (I2C_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam real CONV_NORM_MS = 5.8;
    localparam real CONV_FAST_MS = 2.6;
    localparam int CONV_NORM_CYC = int'(CONV_NORM_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int CONV_FAST_CYC = int'(CONV_FAST_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int CONV_CNT_W = 20;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_RES_HI = 8'h01;
    localparam logic [7:0] REG_RES_LO = 8'h02;
    localparam logic [7:0] REG_CTRL = 8'h03;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_FAST_BIT = 5;
    localparam int STATUS_RDY_N_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam int CODE_W = 12;
    localparam int FAST_DROP_BITS = 2;
    localparam logic [7:0] RH_CODE_DIV_SHIFT = 8'h04;
    localparam logic [7:0] RH_OFFSET = 8'h18;
    localparam logic [7:0] RH_MAX = 8'h64;
endpackage : hum_pkg

// >>> rtl/hum_i2c_if.sv
// open-drain two-wire link between the sensor end and the master end
// assumes pull-ups: a released line reads high
interface hum_i2c_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    assign scl = (host_scl_oe && !host_scl_o) ? 1'b0 : 1'b1;
    assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)) ? 1'b0 : 1'b1;

    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface : hum_i2c_if

// >>> rtl/hum_dev_end.sv
// sensor end: two-wire slave, register file and humidity conversion timer
// assumes the master end never clocks faster than the fast-mode bus rate
module hum_dev_end
    import hum_pkg::*;
#(
    parameter int unsigned NORM_CYC = CONV_NORM_CYC,
    parameter int unsigned FAST_CYC = CONV_FAST_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // two-wire link
    hum_i2c_if.device bus,
    // sensing core
    input wire logic [CODE_W-1:0] humidity_code_i,
    output logic conv_active_o,
    output logic fast_mode_o
);
    typedef enum logic [5:0] {
        DS_IDLE = 6'b000001,
        DS_ADDR = 6'b000010,
        DS_ACK = 6'b000100,
        DS_WRITE = 6'b001000,
        DS_READ = 6'b010000,
        DS_MACK = 6'b100000
    } hum_dev_state_e;

    hum_dev_state_e state, next_state;
    logic [2:0] scl_sync, next_scl_sync, sda_sync, next_sda_sync;
    logic scl_f, next_scl_f, sda_f, next_sda_f;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, ptr, next_ptr, ctrl, next_ctrl;
    logic ptr_ok, next_ptr_ok, is_read, next_is_read, mack_nack, next_mack_nack;
    logic sda_oe, next_sda_oe, launch, next_launch;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic busy, next_busy, ready_n, next_ready_n;
    logic [CONV_CNT_W-1:0] cnt, next_cnt;
    logic [7:0] res_hi, next_res_hi, res_lo, next_res_lo;
    logic [CODE_W-1:0] code_eff;

    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr == REG_STATUS) begin
            val[STATUS_RDY_N_BIT] = ready_n;
        end else if (addr == REG_RES_HI) begin
            val = res_hi;
        end else if (addr == REG_RES_LO) begin
            val = res_lo;
        end else if (addr == REG_CTRL) begin
            val = ctrl;
        end
        return val;
    endfunction : read_reg

    // serial engine
    always_comb begin
        next_scl_sync = {scl_sync[1:0], bus.scl};
        next_sda_sync = {sda_sync[1:0], bus.sda};
        next_scl_f = scl_f;
        next_sda_f = sda_f;
        // a level counts only once the second and third stages agree
        if (scl_sync[1] == scl_sync[2]) begin
            next_scl_f = scl_sync[2];
        end
        if (sda_sync[1] == sda_sync[2]) begin
            next_sda_f = sda_sync[2];
        end
        scl_rise = !scl_f && next_scl_f;
        scl_fall = scl_f && !next_scl_f;
        bus_start = scl_f && next_scl_f && sda_f && !next_sda_f;
        bus_stop = scl_f && next_scl_f && !sda_f && next_sda_f;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_ptr_ok = ptr_ok;
        next_is_read = is_read;
        next_mack_nack = mack_nack;
        next_sda_oe = sda_oe;
        next_ctrl = ctrl;
        next_launch = 1'b0;
        if (bus_stop) begin
            next_state = DS_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_state = DS_ADDR;
            next_bit_cnt = 4'h0;
            next_ptr_ok = 1'b0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                DS_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_f};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_bit_cnt = 4'h0;
                        if (shreg[7:1] == DEV_ADDR) begin
                            next_state = DS_ACK;
                            next_sda_oe = 1'b1;
                            next_is_read = shreg[0];
                        end else begin
                            next_state = DS_IDLE;
                        end
                    end
                end
                DS_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (is_read) begin
                            next_state = DS_READ;
                            next_shreg = read_reg(ptr);
                            next_sda_oe = !next_shreg[7];
                        end else begin
                            next_state = DS_WRITE;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                DS_WRITE: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_f};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_state = DS_ACK;
                        next_sda_oe = 1'b1;
                        if (!ptr_ok) begin
                            next_ptr = shreg;
                            next_ptr_ok = 1'b1;
                        end else begin
                            if (ptr == REG_CTRL) begin
                                next_ctrl = shreg;
                                next_launch = shreg[CTRL_START_BIT];
                            end
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                DS_READ: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_state = DS_MACK;
                            next_sda_oe = 1'b0;
                            next_ptr = ptr + 8'h01;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = !shreg[6];
                        end
                    end
                end
                DS_MACK: begin
                    if (scl_rise) begin
                        next_mack_nack = sda_f;
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (!mack_nack) begin
                            next_state = DS_READ;
                            next_shreg = read_reg(ptr);
                            next_sda_oe = !next_shreg[7];
                        end else begin
                            next_state = DS_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= DS_IDLE;
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            ptr_ok <= 1'b0;
            is_read <= 1'b0;
            mack_nack <= 1'b0;
            sda_oe <= 1'b0;
            ctrl <= CTRL_RESET;
            launch <= 1'b0;
        end else begin
            state <= next_state;
            scl_sync <= next_scl_sync;
            sda_sync <= next_sda_sync;
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            ptr_ok <= next_ptr_ok;
            is_read <= next_is_read;
            mack_nack <= next_mack_nack;
            sda_oe <= next_sda_oe;
            ctrl <= next_ctrl;
            launch <= next_launch;
        end
    end

    // conversion timer; fast mode trades the lowest code bits for time
    always_comb begin
        code_eff = humidity_code_i;
        if (ctrl[CTRL_FAST_BIT]) begin
            code_eff[FAST_DROP_BITS-1:0] = '0;
        end
        next_busy = busy;
        next_ready_n = ready_n;
        next_cnt = cnt;
        next_res_hi = res_hi;
        next_res_lo = res_lo;
        if (launch) begin
            next_busy = 1'b1;
            next_ready_n = 1'b1;
            if (ctrl[CTRL_FAST_BIT]) begin
                next_cnt = CONV_CNT_W'(FAST_CYC - 1);
            end else begin
                next_cnt = CONV_CNT_W'(NORM_CYC - 1);
            end
        end else if (busy) begin
            if (cnt == '0) begin
                // both bytes load in the same edge that drops the flag
                next_busy = 1'b0;
                next_res_hi = code_eff[CODE_W-1:4];
                next_res_lo = {code_eff[3:0], 4'h0};
                next_ready_n = 1'b0;
            end else begin
                next_cnt = cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy <= 1'b0;
            ready_n <= 1'b1;
            cnt <= '0;
            res_hi <= RESULT_RESET;
            res_lo <= RESULT_RESET;
        end else begin
            busy <= next_busy;
            ready_n <= next_ready_n;
            cnt <= next_cnt;
            res_hi <= next_res_hi;
            res_lo <= next_res_lo;
        end
    end

    assign bus.dev_sda_oe = sda_oe;
    assign bus.dev_sda_o = 1'b0;
    assign conv_active_o = busy;
    assign fast_mode_o = ctrl[CTRL_FAST_BIT];
endmodule : hum_dev_end

// >>> verification/hum_link_props.sv
// wire and timer checks for the humidity link
// assumes one clock and reset shared by both ends
module hum_props #(
    parameter int unsigned NORM_CYC = 200,
    parameter int unsigned FAST_CYC = 100
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic conv_active_o,
    input wire logic fast_mode_o,
    input wire logic busy_o,
    input wire logic done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] run;
    logic [31:0] next_run;
    always_comb next_run = conv_active_o ? run + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) run <= 32'h0;
        else run <= next_run;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_len; $fell(conv_active_o) |-> run == (fast_mode_o ? FAST_CYC : NORM_CYC); endproperty
    a_len: assert property (p_len) else $error("conversion length");
    property p_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
    a_hold: assert property (p_hold) else $error("sda moved in scl high");
    property p_ack; $rose(dev_sda_oe) |-> !scl; endproperty
    a_ack: assert property (p_ack) else $error("ack not in scl low");
    property p_launch; $rose(conv_active_o) |-> busy_o; endproperty
    a_launch: assert property (p_launch) else $error("launch without write");
    property p_fast; $changed(fast_mode_o) |-> busy_o; endproperty
    a_fast: assert property (p_fast) else $error("mode changed idle");
    property p_idle; !busy_o |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe; endproperty
    a_idle: assert property (p_idle) else $error("bus held while idle");
    property p_low; $fell(scl) |-> !scl [*8]; endproperty
    a_low: assert property (p_low) else $error("scl low too short");
    property p_done; done_o |-> !conv_active_o ##1 !done_o; endproperty
    a_done: assert property (p_done) else $error("done before ready");
endmodule : hum_props

// >>> verification/tb_top.sv
// self-checking bench: sensor end and master end on one link
// assumes package, interface and both ends compiled first
module tb_top import hum_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic meas_start_i = 1'b0;
    logic fast_i = 1'b0;
    logic [CODE_W-1:0] humidity_code_i = 12'h000;
    logic conv_active_o, fast_mode_o, busy_o, done_o, nack_o;
    logic [CODE_W-1:0] humidity_code_o;
    logic [7:0] rh_percent_o;
    int failures = 0;
    int tests_run = 0;
    // edge codes of the percent range plus clamp cases; last two in fast mode
    logic [CODE_W-1:0] codes [6] = '{12'h180, 12'h7c0, 12'h4a0, 12'h0ff, 12'hfff, 12'h7c3};
    logic [5:0] fast_set = 6'h30;
    hum_i2c_if link ();
    always #5 sys_clk_i = ~sys_clk_i;
    // conversions outlast the first status poll, so the master has to poll again
    hum_dev_end #(.NORM_CYC(2000), .FAST_CYC(1200)) u_hum_dev_end (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .bus(link.device), .humidity_code_i(humidity_code_i),
        .conv_active_o(conv_active_o), .fast_mode_o(fast_mode_o));
    hum_host_end #(.QUARTER_CYC(8)) u_hum_host_end (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .bus(link.host), .meas_start_i(meas_start_i), .fast_i(fast_i), .busy_o(busy_o),
        .done_o(done_o), .nack_o(nack_o), .humidity_code_o(humidity_code_o),
        .rh_percent_o(rh_percent_o));
    hum_props #(.NORM_CYC(2000), .FAST_CYC(1200)) u_hum_props (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
        .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .conv_active_o(conv_active_o),
        .fast_mode_o(fast_mode_o), .busy_o(busy_o), .done_o(done_o));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic measure(input logic [CODE_W-1:0] code, input logic fast);
        logic [CODE_W-1:0] exp_code;
        int pct;
        int n;
        exp_code = fast ? {code[11:2], 2'b00} : code;
        pct = int'(exp_code) / 16 - 24;
        pct = pct < 0 ? 0 : (pct > 100 ? 100 : pct);
        humidity_code_i = code;
        fast_i = fast;
        meas_start_i = 1'b1;
        @(negedge sys_clk_i);
        meas_start_i = 1'b0;
        @(negedge sys_clk_i);
        check(busy_o, 32'h1, "busy");
        n = 0;
        while (done_o !== 1'b1 && n < 20000) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(n < 20000, 32'h1, "done");
        @(negedge sys_clk_i);
        check(humidity_code_o, exp_code, "code");
        check(rh_percent_o, pct, "percent");
        check(nack_o, 32'h0, "nack");
        check(fast_mode_o, fast, "fast");
        check(conv_active_o, 32'h0, "active");
    endtask : measure
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        check(busy_o, 32'h0, "idle");
        // back to back, no gap between measurements
        for (int i = 0; i < 6; i++) begin
            measure(codes[i], fast_set[i]);
        end
        finish_test();
    end
    initial begin
        #(100000 * CLK_PERIOD_NS);
        failures++;
        $display("MISMATCH at %0t: watchdog", $time);
        finish_test();
    end
endmodule : tb_top
